// [src/homing_probe_io_objects.sv]
// homing sequencer, touch-probe objects and digital i/o objects of the drive
//
// Operation
// - method 10: positive, far-side switch fall, index
// - method 11: negative, near-side switch fall, index
// - method 12: negative, near-side switch rise, index
// - methods 13/14: negative, far-side rise/fall, index
// - methods 26-30: as 10-14, home at switch
// - methods 33/34: index only, negative/positive
// - method 35: present position is home, no motion
// - control bits 0/8 enable probes one/two
// - control bits 1/9: single or continuous capture
// - control bit 2: probe one latch pin or index
// - control bit 10: probe two latch pin or index
// - control bits 4/5 arm probe one edges
// - control bits 12/13 arm probe two edges
// - output valid word bits 16-21, reset zero
// - output enable word bits 16-21, reset zero
`default_nettype none
`include "hpio_cfg.svh"
module homing_probe_io_objects (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire hpio_pkg::obj_req_s i_obj,
    output hpio_pkg::obj_rsp_s o_obj,
    input wire hpio_pkg::pins_s i_pins,
    input wire logic [5:0] i_dev_out,
    output logic [5:0] o_gp_out,
    output logic o_probe1_rise,
    output logic o_probe1_fall,
    output logic o_probe2_rise,
    output logic o_probe2_fall,
    input wire logic i_home_start,
    input wire logic [7:0] i_home_method,
    output hpio_pkg::home_cmd_s o_home_cmd,
    output logic o_home_set,
    output logic o_home_done,
    output logic o_home_err
);
    import hpio_pkg::*;

    typedef struct packed {
        logic [15:0] probe_ctrl;
        logic [5:0] out_valid;
        logic [5:0] out_en;
        logic [5:0] gp_out;
        obj_rsp_s rsp;
        home_state_e hstate;
        logic dir_pos;
        logic use_index;
        logic qual_fall;
        logic far_side;
        logic seen;
        logic sw_q;
        logic z_q;
        logic home_set;
        logic fast;
        logic slow;
    } main_state_s;

    main_state_s st_q;
    main_state_s st_d;
    pins_s pins;
    probe_cfg_s cfg1;
    probe_cfg_s cfg2;
    probe_stat_s stat1;
    probe_stat_s stat2;
    logic sw_rise;
    logic sw_fall;
    logic z_rise;
    logic [7:0] base_m;
    logic no_index;
    logic idle_like;

    ////////////////////////////////////////////////////////////////////////
    // field helpers

    function automatic probe_cfg_s ctrl_to_cfg(input logic [7:0] c);
        probe_cfg_s r;
        r.en = c[`PC_EN];
        r.cont = c[`PC_MODE];
        r.src_index = c[`PC_SRC];
        r.rise_en = c[`PC_RISE];
        r.fall_en = c[`PC_FALL];
        return r;
    endfunction

    function automatic logic [31:0] in_word(input pins_s p);
        logic [31:0] w;
        w = '0;
        w[`IS_NEG] = p.neg_limit;
        w[`IS_POS] = p.positive_overtravel_limit;
        w[`IS_HOME] = p.home_switch;
        w[`IS_GP_MSB:`IS_GP_LSB] = p.gp_in;
        w[`IS_ESTOP] = p.emergency_stop;
        w[`IS_INPOS] = p.in_position_speed_match_torque_limit;
        w[`IS_BRAKE] = p.brake;
        w[`IS_PRB1] = p.outside_latch_input_one;
        w[`IS_PRB2] = p.outside_latch_input_two;
        w[`IS_Z] = p.index_pulse;
        return w;
    endfunction

    function automatic logic [31:0] probe_word(input probe_stat_s a,
        input probe_stat_s b);
        logic [31:0] w;
        w = '0;
        w[`PS_EN] = a.en;
        w[`PS_RISE] = a.rise_done;
        w[`PS_FALL] = a.fall_done;
        w[`PS_EN + `P2_OFS] = b.en;
        w[`PS_RISE + `P2_OFS] = b.rise_done;
        w[`PS_FALL + `P2_OFS] = b.fall_done;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pins and probe channels

    pin_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_pins(i_pins),
        .o_pins(pins)
    );

    assign cfg1 = ctrl_to_cfg(st_q.probe_ctrl[7:0]);
    assign cfg2 = ctrl_to_cfg(st_q.probe_ctrl[15:8]);

    probe_channel u_probe1 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_cfg(cfg1),
        .i_latch_pin(pins.outside_latch_input_one),
        .i_index(pins.index_pulse),
        .o_stat(stat1),
        .o_cap_rise(o_probe1_rise),
        .o_cap_fall(o_probe1_fall)
    );

    probe_channel u_probe2 (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_cfg(cfg2),
        .i_latch_pin(pins.outside_latch_input_two),
        .i_index(pins.index_pulse),
        .o_stat(stat2),
        .o_cap_rise(o_probe2_rise),
        .o_cap_fall(o_probe2_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        st_d = st_q;
        sw_rise = pins.home_switch && !st_q.sw_q;
        sw_fall = !pins.home_switch && st_q.sw_q;
        z_rise = pins.index_pulse && !st_q.z_q;
        no_index = (i_home_method >= `HM_NOZ_FIRST) && (i_home_method <= `HM_NOZ_LAST);
        base_m = no_index ? i_home_method - `HM_NOZ_SHIFT : i_home_method;
        idle_like = (st_q.hstate == H_IDLE) || (st_q.hstate == H_DONE)
            || (st_q.hstate == H_FAULT);
        st_d.sw_q = pins.home_switch;
        st_d.z_q = pins.index_pulse;
        st_d.home_set = 1'b0;

        // object access: answer one cycle after the request
        st_d.rsp.ack = i_obj.wr || i_obj.rd;
        st_d.rsp.err = 1'b0;
        st_d.rsp.rdata = '0;
        if (i_obj.wr)
        begin
            if (i_obj.index == `IDX_PROBE_CTRL && i_obj.sub == `SUB_MAIN)
                st_d.probe_ctrl = i_obj.wdata[15:0];
            else if (i_obj.index == `IDX_OUT_WORD && i_obj.sub == `SUB_OUT_VALID)
                st_d.out_valid = i_obj.wdata[`OUT_MSB:`OUT_LSB];
            else if (i_obj.index == `IDX_OUT_WORD && i_obj.sub == `SUB_OUT_EN)
                st_d.out_en = i_obj.wdata[`OUT_MSB:`OUT_LSB];
            else
                st_d.rsp.err = 1'b1;
        end
        else if (i_obj.rd)
        begin
            unique case (i_obj.index)
                `IDX_PROBE_CTRL:
                    st_d.rsp.rdata = {16'h0000, st_q.probe_ctrl};
                `IDX_PROBE_STAT:
                    st_d.rsp.rdata = probe_word(stat1, stat2);
                `IDX_IN_STAT:
                    st_d.rsp.rdata = in_word(pins);
                `IDX_OUT_WORD:
                begin
                    if (i_obj.sub == `SUB_MAIN)
                        st_d.rsp.rdata = `OUT_SUB_COUNT;
                    else if (i_obj.sub == `SUB_OUT_VALID)
                        st_d.rsp.rdata[`OUT_MSB:`OUT_LSB] = st_q.out_valid;
                    else if (i_obj.sub == `SUB_OUT_EN)
                        st_d.rsp.rdata[`OUT_MSB:`OUT_LSB] = st_q.out_en;
                    else
                        st_d.rsp.err = 1'b1;
                end
                default:
                    st_d.rsp.err = 1'b1;
            endcase
            if ((i_obj.index != `IDX_OUT_WORD) && (i_obj.sub != `SUB_MAIN))
            begin
                st_d.rsp.err = 1'b1;
                st_d.rsp.rdata = '0;
            end
        end

        // general outputs
        st_d.gp_out = (st_q.out_en & st_q.out_valid)
            | (~st_q.out_en & i_dev_out);

        // homing sequencer
        unique case (st_q.hstate)
            H_IDLE, H_DONE, H_FAULT:
            begin
                st_d.fast = 1'b0;
                st_d.slow = 1'b0;
            end
            H_FAST:
            begin
                // switch entry is the slow-down point
                if (sw_rise)
                begin
                    st_d.hstate = H_SLOW;
                    st_d.fast = 1'b0;
                    st_d.slow = 1'b1;
                    st_d.seen = !st_q.qual_fall;
                end
            end
            H_SLOW:
            begin
                if (sw_fall)
                    st_d.seen = 1'b1;
                if (st_d.seen && !(st_q.far_side && pins.home_switch))
                begin
                    if (st_q.use_index)
                        st_d.hstate = H_WAITZ;
                    else
                    begin
                        st_d.hstate = H_DONE;
                        st_d.slow = 1'b0;
                        st_d.home_set = 1'b1;
                    end
                end
            end
            H_WAITZ:
            begin
                if (z_rise)
                begin
                    st_d.hstate = H_DONE;
                    st_d.slow = 1'b0;
                    st_d.home_set = 1'b1;
                end
            end
            default:
            begin
                st_d.hstate = H_FAULT;
                st_d.fast = 1'b0;
                st_d.slow = 1'b0;
            end
        endcase

        // a start request is taken only while no search is running
        if (i_home_start && idle_like)
        begin
            st_d.use_index = !no_index;
            st_d.seen = 1'b0;
            st_d.fast = 1'b1;
            st_d.slow = 1'b0;
            st_d.hstate = H_FAST;
            st_d.dir_pos = 1'b0;
            st_d.far_side = 1'b0;
            st_d.qual_fall = 1'b0;
            unique case (base_m)
                `HM_POS_FAR_FALL:
                begin
                    st_d.dir_pos = 1'b1;
                    st_d.far_side = 1'b1;
                    st_d.qual_fall = 1'b1;
                end
                `HM_NEG_NEAR_FALL:
                    st_d.qual_fall = 1'b1;
                `HM_NEG_NEAR_RISE:
                    st_d.qual_fall = 1'b0;
                `HM_NEG_FAR_RISE:
                    st_d.far_side = 1'b1;
                `HM_NEG_FAR_FALL:
                begin
                    st_d.far_side = 1'b1;
                    st_d.qual_fall = 1'b1;
                end
                `HM_Z_NEG, `HM_Z_POS:
                begin
                    st_d.dir_pos = (i_home_method == `HM_Z_POS);
                    st_d.use_index = 1'b1;
                    st_d.fast = 1'b0;
                    st_d.slow = 1'b1;
                    st_d.hstate = H_WAITZ;
                end
                `HM_HERE:
                begin
                    st_d.fast = 1'b0;
                    st_d.hstate = H_DONE;
                    st_d.home_set = 1'b1;
                end
                default:
                begin
                    st_d.fast = 1'b0;
                    st_d.hstate = H_FAULT;
                end
            endcase
            if (no_index && (i_home_method == `HM_Z_NEG || i_home_method == `HM_Z_POS
                || i_home_method == `HM_HERE))
                st_d.hstate = H_FAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            st_q <= '0;
            st_q.probe_ctrl <= `PROBE_CTRL_RST;
            st_q.out_valid <= `OUT_WORD_RST;
            st_q.out_en <= `OUT_WORD_RST;
            st_q.hstate <= H_IDLE;
        end
        else
            st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_obj = st_q.rsp;
    assign o_gp_out = st_q.gp_out;
    assign o_home_cmd = '{dir_pos: st_q.dir_pos, fast: st_q.fast, slow: st_q.slow};
    assign o_home_set = st_q.home_set;
    assign o_home_done = (st_q.hstate == H_DONE);
    assign o_home_err = (st_q.hstate == H_FAULT);
endmodule
`default_nettype wire

// [src/hpio_cfg.svh]
// constants for the homing, touch-probe and digital i/o object block
`ifndef HPIO_CFG_SVH
`define HPIO_CFG_SVH
// object indices and sub-indices
`define IDX_PROBE_CTRL 16'h60b8
`define IDX_PROBE_STAT 16'h60b9
`define IDX_IN_STAT 16'h60fd
`define IDX_OUT_WORD 16'h60fe
`define SUB_MAIN 8'h00
`define SUB_OUT_VALID 8'h01
`define SUB_OUT_EN 8'h02
`define OUT_SUB_COUNT 32'h0000_0002
// reset values
`define PROBE_CTRL_RST 16'h0000
`define OUT_WORD_RST 6'h00
// widths
`define N_GP_IN 14
`define N_GP_OUT 6
// probe control / status fields, probe two sits one byte up
`define PC_EN 0
`define PC_MODE 1
`define PC_SRC 2
`define PC_RISE 4
`define PC_FALL 5
`define P2_OFS 8
`define PS_EN 0
`define PS_RISE 1
`define PS_FALL 2
// output word fields
`define OUT_LSB 16
`define OUT_MSB 21
// input status fields
`define IS_NEG 0
`define IS_POS 1
`define IS_HOME 2
`define IS_GP_LSB 4
`define IS_GP_MSB 17
`define IS_ESTOP 23
`define IS_INPOS 24
`define IS_BRAKE 25
`define IS_PRB1 26
`define IS_PRB2 27
`define IS_Z 31
// homing method codes
`define HM_FIRST_SW 8'h0a
`define HM_POS_FAR_FALL 8'h0a
`define HM_NEG_NEAR_FALL 8'h0b
`define HM_NEG_NEAR_RISE 8'h0c
`define HM_NEG_FAR_RISE 8'h0d
`define HM_NEG_FAR_FALL 8'h0e
`define HM_NOZ_FIRST 8'h1a
`define HM_NOZ_LAST 8'h1e
`define HM_NOZ_SHIFT 8'h10
`define HM_Z_NEG 8'h21
`define HM_Z_POS 8'h22
`define HM_HERE 8'h23
`endif

// [src/hpio_pkg.sv]
// types shared by the homing, touch-probe and digital i/o object block
`default_nettype none
package hpio_pkg;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] index;
        logic [7:0] sub;
        logic [31:0] wdata;
    } obj_req_s;
    typedef struct packed {
        logic ack;
        logic err;
        logic [31:0] rdata;
    } obj_rsp_s;
    typedef struct packed {
        logic neg_limit;
        logic positive_overtravel_limit;
        logic home_switch;
        logic [13:0] gp_in;
        logic emergency_stop;
        logic in_position_speed_match_torque_limit;
        logic brake;
        logic outside_latch_input_one;
        logic outside_latch_input_two;
        logic index_pulse;
    } pins_s;
    typedef struct packed {
        pins_s s1;
        pins_s s2;
        pins_s s3;
        pins_s clean;
    } sync_state_s;
    typedef struct packed {
        logic en;
        logic cont;
        logic src_index;
        logic rise_en;
        logic fall_en;
    } probe_cfg_s;
    typedef struct packed {
        logic en;
        logic rise_done;
        logic fall_done;
    } probe_stat_s;
    typedef struct packed {
        logic sig_q;
        logic en_q;
        logic locked;
        logic rise_done;
        logic fall_done;
        logic cap_rise;
        logic cap_fall;
    } probe_state_s;
    typedef struct packed {
        logic dir_pos;
        logic fast;
        logic slow;
    } home_cmd_s;
    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_FAST = 3'h1,
        H_SLOW = 3'h3,
        H_WAITZ = 3'h2,
        H_DONE = 3'h6,
        H_FAULT = 3'h4
    } home_state_e;
endpackage
`default_nettype wire

// [src/pin_sync.sv]
// three-stage synchroniser for the drive's input pins
`default_nettype none
`include "hpio_cfg.svh"
module pin_sync (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire hpio_pkg::pins_s i_pins,
    output hpio_pkg::pins_s o_pins
);
    import hpio_pkg::*;

    sync_state_s st_q;
    sync_state_s st_d;

    ////////////////////////////////////////////////////////////////////////
    // a level is taken once stages two and three agree
    always_comb
    begin
        st_d = st_q;
        st_d.s1 = i_pins;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        st_d.clean = (st_q.s2 & st_q.s3) | (st_q.clean & (st_q.s2 | st_q.s3));
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_pins = st_q.clean;
endmodule
`default_nettype wire

// [src/probe_channel.sv]
// one touch-probe latch channel: source select, edge arm, single/continuous
`default_nettype none
`include "hpio_cfg.svh"
module probe_channel (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire hpio_pkg::probe_cfg_s i_cfg,
    input wire logic i_latch_pin,
    input wire logic i_index,
    output hpio_pkg::probe_stat_s o_stat,
    output logic o_cap_rise,
    output logic o_cap_fall
);
    import hpio_pkg::*;

    probe_state_s st_q;
    probe_state_s st_d;
    logic sig;
    logic hit_r;
    logic hit_f;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d = st_q;
        sig = i_cfg.src_index ? i_index : i_latch_pin;
        st_d.sig_q = sig;
        st_d.en_q = i_cfg.en;
        // fresh enable re-arms and clears the executed flags
        if (i_cfg.en && !st_q.en_q)
        begin
            st_d.locked = 1'b0;
            st_d.rise_done = 1'b0;
            st_d.fall_done = 1'b0;
        end
        hit_r = i_cfg.en && i_cfg.rise_en && sig && !st_q.sig_q
            && !st_d.locked;
        hit_f = i_cfg.en && i_cfg.fall_en && !sig && st_q.sig_q
            && !st_d.locked;
        st_d.cap_rise = hit_r;
        st_d.cap_fall = hit_f;
        if (hit_r)
            st_d.rise_done = 1'b1;
        if (hit_f)
            st_d.fall_done = 1'b1;
        if ((hit_r || hit_f) && !i_cfg.cont)
            st_d.locked = 1'b1;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign o_stat = '{en: st_q.en_q, rise_done: st_q.rise_done, fall_done: st_q.fall_done};
    assign o_cap_rise = st_q.cap_rise;
    assign o_cap_fall = st_q.cap_fall;
endmodule
`default_nettype wire

// [test/hpio_properties.sv]
// concurrent checks on the object, probe, homing and output ports
`default_nettype none
module hpio_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire hpio_pkg::obj_req_s i_obj,
    input wire hpio_pkg::obj_rsp_s o_obj,
    input wire logic [5:0] i_dev_out,
    input wire logic [5:0] o_gp_out,
    input wire logic o_probe1_rise,
    input wire logic o_probe1_fall,
    input wire logic i_home_start,
    input wire logic [7:0] i_home_method,
    input wire hpio_pkg::home_cmd_s o_home_cmd,
    input wire logic o_home_set,
    input wire logic o_home_done
);
    import hpio_pkg::*;
    logic [15:0] ctrl_q;
    logic [5:0] oen_q;
    // shadow of the probe control word and the output enable word
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ctrl_q <= 16'h0000;
            oen_q <= 6'h00;
        end
        else if (i_obj.wr && i_obj.index == 16'h60b8 && i_obj.sub == 8'h00)
            ctrl_q <= i_obj.wdata[15:0];
        else if (i_obj.wr && i_obj.index == 16'h60fe && i_obj.sub == 8'h02)
            oen_q <= i_obj.wdata[21:16];
    end
    ////////////////////////////////////////
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_start(int m);
        i_home_start && i_home_method == m && !o_home_cmd.fast && !o_home_cmd.slow;
    endsequence
    sequence s_p1_off;
        !ctrl_q[0] [*3];
    endsequence
    req_ack_a: assert property (
        (i_obj.wr || i_obj.rd) |=> o_obj.ack)
        else $error("request not answered on the next edge");
    ro_err_a: assert property (
        i_obj.wr && i_obj.index == 16'h60b9 |=> o_obj.ack && o_obj.err)
        else $error("write to probe status not refused");
    home_here_a: assert property (
        s_start(35) |=> o_home_set && o_home_done && o_home_cmd == 3'h0)
        else $error("method 35 did not set home at once");
    home_zneg_a: assert property (
        s_start(33) |=> o_home_cmd == 3'h1)
        else $error("method 33 not a slow negative search");
    home_pos_a: assert property (
        s_start(10) |=> o_home_cmd == 3'h6)
        else $error("method 10 not a fast positive search");
    home_neg_a: assert property (
        i_home_start && i_home_method inside {[8'h0b:8'h0e]} && !o_home_cmd.fast
        && !o_home_cmd.slow
        |=> o_home_cmd == 3'h2)
        else $error("methods 11 to 14 not a fast negative search");
    probe_off_a: assert property (
        s_p1_off |-> !o_probe1_rise && !o_probe1_fall)
        else $error("capture on a disabled probe");
    out_dev_a: assert property (
        oen_q == 6'h00 && $past(oen_q) == 6'h00 && $past(oen_q, 2) == 6'h00 && $past(i_rst_n)
        |-> o_gp_out == $past(i_dev_out))
        else $error("disabled outputs do not follow the device function");
endmodule
bind homing_probe_io_objects hpio_checker chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_obj(i_obj),
    .o_obj(o_obj), .i_dev_out(i_dev_out), .o_gp_out(o_gp_out), .o_probe1_rise(o_probe1_rise),
    .o_probe1_fall(o_probe1_fall), .i_home_start(i_home_start), .i_home_method(i_home_method),
    .o_home_cmd(o_home_cmd), .o_home_set(o_home_set), .o_home_done(o_home_done));
`default_nettype wire

// [test/obj_master.sv]
// object access master standing in for the fieldbus controller
`default_nettype none
module obj_master (
    input wire logic i_clk,
    input wire hpio_pkg::obj_rsp_s i_rsp,
    output var hpio_pkg::obj_req_s o_req
);
    import hpio_pkg::*;
    initial o_req = '0;
    // one request per call; released address and data lines are scrambled
    task automatic xfer(input logic w, input logic [15:0] idx, input logic [7:0] sub,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        @(negedge i_clk);
        o_req <= {w, !w, idx, sub, wd};
        @(negedge i_clk);
        o_req <= {2'b00, ~idx, ~sub, ~wd};
        // the answer stands one cycle: take it at the edge where ack is sampled high
        @(posedge i_clk);
        rd = i_rsp.rdata;
        err = (i_rsp.ack === 1'b1) ? i_rsp.err : 1'bx;
        // hand back off the sampling edge so callers drive inputs safely
        @(negedge i_clk);
    endtask
endmodule
`default_nettype wire

// [test/tb_top.sv]
// self-checking bench for the homing, probe and i/o object block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hpio_pkg::*;
    logic clk, rst_n, hstart, hset, hdone, herr, p1r, p1f, p2r, p2f, er;
    logic [7:0] method;
    logic [5:0] dev_out, gp_out;
    logic [31:0] rd, vw, ew, e;
    obj_req_s req;
    obj_rsp_s rsp;
    pins_s pins;
    home_cmd_s cmd;
    int mismatches, comparisons, cycles, n1r, n1f, n2r, n2f;
    logic [15:0] pc[6] = '{16'h0011, 16'h0033, 16'h0025, 16'h0030, 16'h3300, 16'h1500};
    int pw[6] = '{0, 0, 2, 0, 1, 2};
    logic [7:0] hm[11] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h1a, 8'h1e, 8'h21, 8'h22,
        8'h23, 8'h0f};
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    obj_master bm (.i_clk(clk), .i_rsp(rsp), .o_req(req));
    homing_probe_io_objects uut (.i_clk(clk), .i_rst_n(rst_n), .i_obj(req), .o_obj(rsp),
        .i_pins(pins), .i_dev_out(dev_out), .o_gp_out(gp_out), .o_probe1_rise(p1r),
        .o_probe1_fall(p1f), .o_probe2_rise(p2r), .o_probe2_fall(p2f),
        .i_home_start(hstart), .i_home_method(method), .o_home_cmd(cmd),
        .o_home_set(hset), .o_home_done(hdone), .o_home_err(herr));
    always @(posedge clk)
    begin
        cycles++;
        n1r += p1r;
        n1f += p1f;
        n2r += p2r;
        n2f += p2f;
        if (cycles == 6000)
        begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic set_pin(input int w, input logic v);
        @(negedge clk);
        case (w)
            0: pins.outside_latch_input_one = v;
            1: pins.outside_latch_input_two = v;
            2: pins.index_pulse = v;
            default: pins.home_switch = v;
        endcase
        repeat (8) @(negedge clk);
    endtask
    task automatic pin_pulse(input int w, input int n);
        repeat (n)
        begin
            set_pin(w, 1'b1);
            set_pin(w, 1'b0);
        end
    endtask
    // expected captures for two full pulses: rise/fall counts, probe one low half
    function automatic logic [31:0] model(input logic [15:0] c, input int w);
        logic [31:0] m;
        logic [7:0] b;
        m = 32'h0;
        for (int p = 0; p < 2; p++)
        begin
            b = c[p*8 +: 8];
            if (b[0] && (b[2] ? 2 : p) == w)
                m[p*16 +: 16] = b[1] ? {6'h0, b[5], 1'b0, 6'h0, b[4], 1'b0}
                    : (b[4] ? 16'h0001 : {7'h0, b[5], 8'h00});
        end
        return m;
    endfunction
    function automatic logic [2:0] hexp(input logic [7:0] m);
        if (m == 8'h0a || m == 8'h1a)
            return 3'h6;
        if (m inside {[8'h0b:8'h0e], [8'h1b:8'h1e]})
            return 3'h2;
        if (m == 8'h21 || m == 8'h22)
            return {m == 8'h22, 2'h1};
        return 3'h0;
    endfunction
    initial
    begin
        void'($urandom(1921));
        rst_n = 1'b0;
        hstart = 1'b0;
        method = 8'h00;
        dev_out = 6'h00;
        pins = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        for (int s = 0; s < 3; s++)
        begin
            bm.xfer(1'b0, 16'h60fe, 8'(s), 32'h0, rd, er);
            check(rd, s == 0 ? 32'h2 : 32'h0);
        end
        repeat (4)
        begin
            vw = $urandom;
            ew = $urandom;
            dev_out = 6'($urandom);
            bm.xfer(1'b1, 16'h60fe, 8'h01, vw, rd, er);
            bm.xfer(1'b1, 16'h60fe, 8'h02, ew, rd, er);
            bm.xfer(1'b0, 16'h60fe, 8'h01, 32'h0, rd, er);
            check(rd, vw & 32'h003f_0000);
            bm.xfer(1'b0, 16'h60fe, 8'h02, 32'h0, rd, er);
            check(rd, ew & 32'h003f_0000);
            e = (vw & ew) | ({10'h0, dev_out, 16'h0} & ~ew);
            check(32'(gp_out), 32'(e[21:16]));
        end
        vw = $urandom;
        bm.xfer(1'b1, 16'h60b8, 8'h00, vw, rd, er);
        bm.xfer(1'b0, 16'h60b8, 8'h00, 32'h0, rd, er);
        check(rd, vw & 32'hffff);
        bm.xfer(1'b0, 16'h60b9, 8'h00, 32'h0, rd, er);
        check(rd, vw & 32'h0101);
        bm.xfer(1'b1, 16'h60b9, 8'h00, 32'hffff, rd, er);
        check(32'(er), 32'h1);
        bm.xfer(1'b1, 16'h60fd, 8'h00, 32'hffff, rd, er);
        check(32'(er), 32'h1);
        repeat (4)
        begin
            vw = $urandom;
            pins = vw[22:0];
            repeat (6) @(negedge clk);
            bm.xfer(1'b0, 16'h60fd, 8'h00, 32'h0, rd, er);
            check(rd, {pins.index_pulse, 3'h0, pins.outside_latch_input_two,
                pins.outside_latch_input_one, pins.brake, pins.in_position_speed_match_torque_limit,
                pins.emergency_stop, 5'h0, pins.gp_in, 1'b0, pins.home_switch,
                pins.positive_overtravel_limit, pins.neg_limit});
        end
        pins = '0;
        foreach (pc[i])
        begin
            bm.xfer(1'b1, 16'h60b8, 8'h00, 32'h0, rd, er);
            bm.xfer(1'b1, 16'h60b8, 8'h00, 32'h0101, rd, er);
            bm.xfer(1'b1, 16'h60b8, 8'h00, {16'h0, pc[i]}, rd, er);
            repeat (3) @(negedge clk);
            {n1r, n1f, n2r, n2f} = '0;
            pin_pulse(pw[i], 2);
            e = model(pc[i], pw[i]);
            check({n2f[7:0], n2r[7:0], n1f[7:0], n1r[7:0]}, e);
            bm.xfer(1'b0, 16'h60b9, 8'h00, 32'h0, rd, er);
            check(rd, {21'h0, |e[31:24], |e[23:16], pc[i][8], 5'h0,
                |e[15:8], |e[7:0], pc[i][0]});
        end
        foreach (hm[i])
        begin
            @(negedge clk);
            method = hm[i];
            hstart = 1'b1;
            @(negedge clk);
            hstart = 1'b0;
            check(32'(cmd), 32'(hexp(hm[i])));
            pin_pulse(3, 1);
            pin_pulse(2, 1);
            check({hdone, herr}, hm[i] == 8'h0f ? 32'h1 : 32'h2);
        end
        finish_test();
    end
endmodule
`default_nettype wire
